//--- verilog/flash_unlock_protect_program_control.sv
// Flash access gating: unlock sequence, sector protect, erase/program control and CPU stall
// What this block does
// - Timing is correct for system clocks between 1 MHz and 8 MHz; mass erase is timed at 50 ms, not 200 ms.
// - System clock is crystal, or crystal divided by 2, 16 or 32.
// - After reset the controller is locked and allows no erase, program or port array read.
// - Unlock: page, 73H, 8CH, then same page again.
// - A wrong command or page write in the unlock sequence returns to locked; timing register writes do not.
// - While unlocked, 95H erases the selected page.
// - CPU operations need an unprotected sector; port and info area ignore protection.
// - Page stays unlocked after a byte program completes.
// - Command write other than 95H or 63H relocks after programming completes.
// - Completed page or mass erase relocks automatically.
// - CPU write to page select while unlocked relocks.
// - Option protect bits override unlocking for external accesses.
// - Sector spans 16 pages of 512 bytes; 4 or 8 sectors.
// - 5EH while locked redirects next page-address write to sector protect.
// - Sector protect resets to 0; a 1 blocks CPU program and erase.
// - Set protect bits cannot be cleared until power loss.
// - CPU programs main memory only; port may program info page 3.
// - Mass erase opens all main memory; page erase opens that page only.
// - Programming only clears bits; erase leaves bytes at FFH.
// - CPU clock stops during a CPU program and resumes afterwards.
// - Mass erase 63H is ignored from CPU, executed from port when unlocked.
// - State code reads 0,1,2,3 and 4 for locked, keys, unlocked, sector select; 8 while an operation is busy.
module flash_unlock_protect_program_control
  import flash_ctl_pkg::*;
#(
  parameter int NUM_SECTORS = 8,
  parameter int NUM_PAGES   = 128
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // Clock source straps
  input  wire logic       option_div_bit,
  input  wire logic       stop_recovery_config,
  // Option-byte protect bits (external accesses)
  input  wire logic       opt_block_info_erase,
  input  wire logic       opt_block_main_read,
  input  wire logic       opt_block_main_write,
  // Register access
  input  wire reg_req_t   req,
  output logic [7:0]      rdata,
  // Byte program request and array read gate
  input  wire prog_req_t  prog,
  input  wire logic [7:0] prog_old_byte,
  input  wire logic       port_read,
  output logic            read_allow,
  // Array operation and stall
  output flash_op_t       op,
  output logic            op_busy,
  output logic            cpu_clk_stall
);
  lock_state_t                 state_r;
  logic [7:0]                  page_r;
  logic [7:0]                  page_first_r;
  logic [15:0]                 timing_r;
  logic [NUM_SECTORS-1:0]      protect_r;
  logic [NUM_PAGES-1:0]        open_r;
  logic                        op_cpu_r;
  op_kind_t                    op_kind_r;
  flash_op_t                   op_r;
  logic [7:0]                  rdata_r;
  logic                        tick;
  logic                        busy;
  logic                        done;
  logic                        is_info;
  logic                        page_prot;
  logic                        ext_block;
  logic                        op_ok;
  logic                        wr_cmd;
  logic                        wr_page;
  logic                        start_perase;
  logic                        start_merase;
  logic                        start_prog;
  logic [SECTOR_SHIFT+3:0]     sec_idx;

  flash_clk_select u_clk_select (
    .sys_clk              (sys_clk),
    .sys_rst              (sys_rst),
    .clk_en               (clk_en),
    .option_div_bit       (option_div_bit),
    .stop_recovery_config (stop_recovery_config),
    .sys_tick             (tick)
  );

  flash_pulse_timer u_timer (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .tick         (tick),
    .timing_count (timing_r),
    .op           (op_r),
    .busy         (busy),
    .done         (done)
  );

  // Decode of register writes
  assign wr_cmd  = tick & req.wr & (req.addr == ADDR_CMD);
  assign wr_page = tick & req.wr & (req.addr == ADDR_PAGE);

  // Target classification
  assign is_info   = page_r[PAGE_BIT_INFO];
  assign sec_idx   = 8'(page_r >> SECTOR_SHIFT);  // 16 pages a sector
  assign page_prot = !is_info && (int'(sec_idx) < NUM_SECTORS) && protect_r[sec_idx[2:0]];
  // Option bits outrank unlocking for the port side
  assign ext_block = req.from_port &&
                     (is_info ? opt_block_info_erase : opt_block_main_write);
  // CPU honours sector protect; port and info area skip it
  assign op_ok = req.from_port ? !ext_block : (!page_prot && !is_info);

  assign start_perase = wr_cmd && state_r == ST_UNLOCK && !busy &&
                        req.wdata == CMD_PAGE_ERA && op_ok;
  assign start_merase = wr_cmd && state_r == ST_UNLOCK && !busy && req.from_port &&
                        req.wdata == CMD_MASS_ERA && !opt_block_main_write;

  // Byte program needs unlock; CPU also needs an erase-opened main-memory page
  always_comb begin
    start_prog = 1'b0;
    if (tick && prog.valid && state_r == ST_UNLOCK && !busy) begin
      if (prog.from_port) begin
        start_prog = is_info ? (page_r == INFO_PAGE3) : !opt_block_main_write;
      end else begin
        start_prog = !is_info && !page_prot && open_r[page_r[6:0]];
      end
    end
  end

  // Unlock sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r      <= ST_LOCKED;
      page_first_r <= 8'h00;
    end else if (tick) begin
      if (done && (op_kind_r != OP_PROG)) begin
        state_r <= ST_LOCKED;
      end else begin
        case (state_r)
          ST_LOCKED: begin
            if (wr_page) begin
              page_first_r <= req.wdata;
            end else if (wr_cmd) begin
              state_r <= (req.wdata == CMD_KEY1) ? ST_KEY1 :
                         (req.wdata == CMD_SEC_SEL) ? ST_SECSEL : ST_LOCKED;
            end
          end
          ST_KEY1: begin
            if (wr_cmd) state_r <= (req.wdata == CMD_KEY2) ? ST_KEY2 : ST_LOCKED;
            else if (wr_page) state_r <= ST_LOCKED;
          end
          ST_KEY2: begin
            if (wr_page) state_r <= (req.wdata == page_first_r) ? ST_UNLOCK : ST_LOCKED;
            else if (wr_cmd) state_r <= ST_LOCKED;
          end
          ST_UNLOCK: begin
            // Ignores a relock command write while any operation is busy
            if (wr_cmd && !busy && req.wdata != CMD_PAGE_ERA && req.wdata != CMD_MASS_ERA) begin
              state_r <= ST_LOCKED;
            end else if (wr_page && !req.from_port) begin
              state_r <= ST_LOCKED;
            end
          end
          ST_SECSEL: begin
            if (wr_page || wr_cmd) state_r <= ST_LOCKED;
          end
          default: state_r <= ST_LOCKED;
        endcase
      end
    end
  end

  // Page select; write in sector-select state goes to protect mask instead
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      page_r <= 8'h00;
    end else if (wr_page && state_r != ST_SECSEL) begin
      page_r <= req.wdata;
    end
  end

  // Sector protect: bits only set, cleared by reset (power-up) alone
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      protect_r <= '0;
    end else if (wr_page && state_r == ST_SECSEL) begin
      protect_r <= protect_r | req.wdata[NUM_SECTORS-1:0];
    end
  end

  // Timing count bytes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timing_r <= 16'h0000;
    end else if (tick && req.wr) begin
      if (req.addr == ADDR_TIMING_HI) timing_r[15:8] <= req.wdata;
      if (req.addr == ADDR_TIMING_LO) timing_r[7:0]  <= req.wdata;
    end
  end

  // Pages opened for CPU byte programming by an erase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      open_r <= '0;
    end else if (tick && done) begin
      if (op_kind_r == OP_MERASE) open_r <= '1;
      else if (op_kind_r == OP_PERASE && !is_info) open_r[page_r[6:0]] <= 1'b1;
    end
  end

  // Operation launch; program merges old data so bits only fall
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_r      <= '0;
      op_kind_r <= OP_PROG;
      op_cpu_r  <= 1'b0;
    end else if (tick) begin
      op_r.start <= 1'b0;
      if (start_perase || start_merase || start_prog) begin
        op_r.start  <= 1'b1;
        op_r.page   <= page_r;
        op_r.offset <= prog.offset;
        op_r.kind   <= start_prog ? OP_PROG : (start_merase ? OP_MERASE : OP_PERASE);
        op_r.wdata  <= start_prog ? (prog.wdata & prog_old_byte) : ERASED_BYTE;
        op_kind_r   <= start_prog ? OP_PROG : (start_merase ? OP_MERASE : OP_PERASE);
        op_cpu_r    <= start_prog ? !prog.from_port : !req.from_port;
      end
    end
  end

  // Read data: state code at command address
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (tick && req.rd) begin
      case (req.addr)
        ADDR_CMD: begin
          if (busy) rdata_r <= {2'b00, CODE_BUSY};
          else begin
            case (state_r)
              ST_KEY1:   rdata_r <= {2'b00, CODE_KEY1};
              ST_KEY2:   rdata_r <= {2'b00, CODE_KEY2};
              ST_UNLOCK: rdata_r <= {2'b00, CODE_UNLOCK};
              ST_SECSEL: rdata_r <= {2'b00, CODE_SECSEL};
              default:   rdata_r <= {2'b00, CODE_LOCKED};
            endcase
          end
        end
        ADDR_PAGE:      rdata_r <= page_r;
        ADDR_TIMING_HI: rdata_r <= timing_r[15:8];
        ADDR_TIMING_LO: rdata_r <= timing_r[7:0];
        default:        rdata_r <= 8'h00;
      endcase
    end
  end

  // Stall CPU while a CPU program or erase runs; peripherals keep their clock
  assign cpu_clk_stall = (busy || op_r.start) && op_cpu_r;
  // Port array reads blocked when locked and by option bit; CPU reads always allowed
  assign read_allow = (state_r != ST_LOCKED || !port_read) && !(port_read && opt_block_main_read);
  assign op         = op_r;
  assign op_busy    = busy;
  assign rdata      = rdata_r;
endmodule : flash_unlock_protect_program_control

//--- verilog/flash_ctl_pkg.sv
// Package: register addresses, commands, state codes, timing and carrier types of the flash gating block
package flash_ctl_pkg;
  // Register file addresses (bank-relative)
  localparam logic [7:0] ADDR_TIMING_HI = 8'h00;
  localparam logic [7:0] ADDR_CMD       = 8'h01;
  localparam logic [7:0] ADDR_PAGE      = 8'h02;
  localparam logic [7:0] ADDR_TIMING_LO = 8'h03;
  // Command values
  localparam logic [7:0] CMD_KEY1     = 8'h73;
  localparam logic [7:0] CMD_KEY2     = 8'h8C;
  localparam logic [7:0] CMD_PAGE_ERA = 8'h95;
  localparam logic [7:0] CMD_MASS_ERA = 8'h63;
  localparam logic [7:0] CMD_SEC_SEL  = 8'h5E;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  // State codes readable at the command address
  localparam logic [5:0] CODE_LOCKED  = 6'h00;
  localparam logic [5:0] CODE_KEY1    = 6'h01;
  localparam logic [5:0] CODE_KEY2    = 6'h02;
  localparam logic [5:0] CODE_UNLOCK  = 6'h03;
  localparam logic [5:0] CODE_SECSEL  = 6'h04;
  localparam logic [5:0] CODE_BUSY    = 6'h08;
  // Page layout
  localparam int PAGE_BIT_INFO    = 7;
  localparam int PAGES_PER_SECTOR = 16;
  localparam int SECTOR_SHIFT     = 4;
  localparam logic [7:0] INFO_PAGE3 = 8'h83;
  // Timing window in kHz; pulse lengths in microseconds (program) and milliseconds (erase)
  localparam int FREQ_MIN_KHZ   = 1000;
  localparam int FREQ_MAX_KHZ   = 8000;
  localparam int PROG_TIME_US   = 40;
  localparam int PERASE_TIME_MS = 10;
  localparam int MERASE_TIME_MS = 200;
  localparam int US_PER_MS      = 1000;
  // Clock source choices
  localparam logic [1:0] DIV_1 = 2'd0;
  localparam logic [1:0] DIV_2 = 2'd1;
  localparam logic [1:0] DIV_16 = 2'd2;
  localparam logic [1:0] DIV_32 = 2'd3;

  typedef enum logic [4:0] {
    ST_LOCKED = 5'b00001,
    ST_KEY1   = 5'b00010,
    ST_KEY2   = 5'b00100,
    ST_UNLOCK = 5'b01000,
    ST_SECSEL = 5'b10000
  } lock_state_t;

  typedef enum logic [1:0] {
    OP_PROG  = 2'd0,
    OP_PERASE = 2'd1,
    OP_MERASE = 2'd2
  } op_kind_t;

  // Register write/read request from the CPU or programming port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       from_port;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Byte program request
  typedef struct packed {
    logic       valid;
    logic       from_port;
    logic [8:0] offset;
    logic [7:0] wdata;
  } prog_req_t;

  // Operation handed to the array pulse timer
  typedef struct packed {
    logic       start;
    op_kind_t   kind;
    logic [7:0] page;
    logic [8:0] offset;
    logic [7:0] wdata;
  } flash_op_t;
endpackage : flash_ctl_pkg

//--- verilog/flash_clk_select.sv
// Clock enable generator: picks crystal, /2, /16 or /32 for the system clock
module flash_clk_select
  import flash_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Source selection
  input  wire logic option_div_bit,
  input  wire logic stop_recovery_config,
  // Output tick
  output logic      sys_tick
);
  logic [4:0] div_cnt_r;
  logic [1:0] sel;

  // Option bit picks /2 path, recovery bit picks the deep divide
  always_comb begin
    case ({option_div_bit, stop_recovery_config})
      2'b00:   sel = DIV_1;
      2'b10:   sel = DIV_2;
      2'b01:   sel = DIV_16;
      default: sel = DIV_32;
    endcase
  end

  // Free running divider
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_cnt_r <= 5'h00;
    end else if (clk_en) begin
      div_cnt_r <= div_cnt_r + 5'h01;
    end
  end

  // Tick once per divided period
  always_comb begin
    case (sel)
      DIV_1:   sys_tick = clk_en;
      DIV_2:   sys_tick = clk_en & (div_cnt_r[0] == 1'b1);
      DIV_16:  sys_tick = clk_en & (div_cnt_r[3:0] == 4'hF);
      default: sys_tick = clk_en & (div_cnt_r == 5'h1F);
    endcase
  end
endmodule : flash_clk_select

//--- verilog/flash_pulse_timer.sv
// Pulse timer: times program and erase operations from the kHz count
module flash_pulse_timer
  import flash_ctl_pkg::*;
#(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  // Control
  input  wire logic [15:0] timing_count,
  input  wire flash_op_t   op,
  // Status
  output logic             busy,
  output logic             done
);
  logic [CNT_W-1:0] cnt_r;
  logic [15:0]      per_us_r;
  logic [15:0]      us_left_r;
  logic             busy_r;
  logic             done_r;
  logic [15:0]      us_len;

  // Duration in microseconds
  always_comb begin
    case (op.kind)
      OP_PROG:   us_len = 16'(PROG_TIME_US);
      OP_PERASE: us_len = 16'(PERASE_TIME_MS * US_PER_MS);
      default:   us_len = 16'(MERASE_TIME_MS * US_PER_MS / 4);
    endcase
  end

  // Counts kHz/1000 cycles per microsecond; short counts clamp to one
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      cnt_r     <= '0;
      per_us_r  <= 16'h0000;
      us_left_r <= 16'h0000;
    end else if (tick) begin
      done_r <= 1'b0;
      if (!busy_r && op.start) begin
        busy_r    <= 1'b1;
        per_us_r  <= (timing_count < 16'(FREQ_MIN_KHZ)) ? 16'h0001 : 16'(timing_count / 16'(US_PER_MS));
        us_left_r <= us_len;
        cnt_r     <= '0;
      end else if (busy_r) begin
        if (cnt_r + 1'b1 >= CNT_W'(per_us_r)) begin
          cnt_r <= '0;
          if (us_left_r <= 16'h0001) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end else begin
            us_left_r <= us_left_r - 16'h0001;
          end
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule : flash_pulse_timer

//--- tb/flash_ctl_checker.sv
// Checker: port-level properties of the flash gating block
module flash_ctl_checker
  import flash_ctl_pkg::*;
#(
  parameter int NUM_SECTORS = 8,
  parameter int NUM_PAGES   = 128
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  // Straps and option bits
  input wire logic       option_div_bit,
  input wire logic       stop_recovery_config,
  input wire logic       opt_block_info_erase,
  input wire logic       opt_block_main_read,
  input wire logic       opt_block_main_write,
  // Requests and answers
  input wire reg_req_t   req,
  input wire logic [7:0] rdata,
  input wire prog_req_t  prog,
  input wire logic [7:0] prog_old_byte,
  input wire logic       port_read,
  input wire logic       read_allow,
  input wire flash_op_t  op,
  input wire logic       op_busy,
  input wire logic       cpu_clk_stall
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Erases only start from a command write taken the edge before
  property p_erase_cause; op.start && op.kind != OP_PROG |-> $past(req.wr) && $past(req.addr) == ADDR_CMD; endproperty
  a_erase_cause: assert property (p_erase_cause) else $error("erase start without command write");
  property p_prog_cause; op.start && op.kind == OP_PROG |-> $past(prog.valid); endproperty
  a_prog_cause: assert property (p_prog_cause) else $error("program start without request");
  property p_cpu_no_mass;
    req.wr && !req.from_port && req.addr == ADDR_CMD && req.wdata == CMD_MASS_ERA |=> !op.start [*3];
  endproperty
  a_cpu_no_mass: assert property (p_cpu_no_mass) else $error("cpu mass erase started");
  property p_prog_clears; op.start && op.kind == OP_PROG |-> (op.wdata & ~$past(prog_old_byte)) == 8'h00; endproperty
  a_prog_clears: assert property (p_prog_clears) else $error("program sets a bit");
  property p_start_busy; op.start |=> op_busy [*2]; endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy missing after start");
  property p_stall_busy; !op_busy && !op.start |-> !cpu_clk_stall; endproperty
  a_stall_busy: assert property (p_stall_busy) else $error("stall while idle");
  property p_cpu_prog_stall; op.start && op.kind == OP_PROG && !$past(prog.from_port) |=> cpu_clk_stall; endproperty
  a_cpu_prog_stall: assert property (p_cpu_prog_stall) else $error("no stall on cpu program");
  property p_no_restart; $past(op_busy) && op_busy |-> !op.start; endproperty
  a_no_restart: assert property (p_no_restart) else $error("start while busy");
  property p_read_block; port_read && opt_block_main_read |-> !read_allow; endproperty
  a_read_block: assert property (p_read_block) else $error("blocked read allowed");
  property p_rdata_top;
    req.rd && req.addr == ADDR_CMD |=> rdata[7:6] == 2'b00 && (rdata[5:0] <= CODE_SECSEL || rdata[5:0] == CODE_BUSY);
  endproperty
  a_rdata_top: assert property (p_rdata_top) else $error("state code upper bits set");
endmodule : flash_ctl_checker

bind flash_unlock_protect_program_control flash_ctl_checker #(
  .NUM_SECTORS(NUM_SECTORS), .NUM_PAGES(NUM_PAGES)
) u_flash_ctl_checker (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .option_div_bit(option_div_bit), .stop_recovery_config(stop_recovery_config),
  .opt_block_info_erase(opt_block_info_erase), .opt_block_main_read(opt_block_main_read),
  .opt_block_main_write(opt_block_main_write), .req(req), .rdata(rdata), .prog(prog),
  .prog_old_byte(prog_old_byte), .port_read(port_read), .read_allow(read_allow),
  .op(op), .op_busy(op_busy), .cpu_clk_stall(cpu_clk_stall)
);

//--- tb/req_model.sv
// Requester model: CPU or programming-port register writes, reads and byte programs
module req_model
  import flash_ctl_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Requests toward the block
  output reg_req_t  req,
  output prog_req_t prog
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req  = '0;
    prog = '0;
  end
  // Released strobes drop and address/data lines show the inverse of the last value, so a stale copy is never mistaken for a request
  task automatic release_all();
    req  = '{wr:1'b0, rd:1'b0, from_port:req.from_port, addr:~req.addr, wdata:~req.wdata};
    prog = '{valid:1'b0, from_port:prog.from_port, offset:~prog.offset, wdata:~prog.wdata};
  endtask : release_all
  // One access held over exactly one taken edge; tick runs every cycle with straps at 00
  task automatic wr(input logic port, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{wr:1'b1, rd:1'b0, from_port:port, addr:a, wdata:d};
    @(negedge sys_clk);
    release_all();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    req = '{wr:1'b0, rd:1'b1, from_port:1'b0, addr:a, wdata:8'h00};
    @(negedge sys_clk);
    release_all();
  endtask : rd
  task automatic pgm(input logic port, input logic [8:0] off, input logic [7:0] d);
    @(negedge sys_clk);
    prog = '{valid:1'b1, from_port:port, offset:off, wdata:d};
    @(negedge sys_clk);
    release_all();
  endtask : pgm
  // Timing count in kHz, high byte then low byte
  task automatic load_timing(input logic [15:0] khz);
    wr(1'b0, ADDR_TIMING_HI, khz[15:8]);
    wr(1'b0, ADDR_TIMING_LO, khz[7:0]);
  endtask : load_timing
  // Unlock order: page, first key, second key, page again (p2 differs only on purpose)
  task automatic unlock(input logic port, input logic [7:0] p1, input logic [7:0] p2);
    wr(port, ADDR_PAGE, p1);
    wr(port, ADDR_CMD, CMD_KEY1);
    wr(port, ADDR_CMD, CMD_KEY2);
    wr(port, ADDR_PAGE, p2);
  endtask : unlock
  // Sector protect reached only from locked, through the select command
  task automatic protect(input logic [7:0] mask);
    wr(1'b0, ADDR_CMD, CMD_SEC_SEL);
    wr(1'b0, ADDR_PAGE, mask);
  endtask : protect
endmodule : req_model

//--- tb/testbench.sv
// Testbench: self-checking scenarios for the flash gating block
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, (e), (g)); end end
module testbench
  import flash_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk, sys_rst, clk_en, option_div_bit, stop_recovery_config;
  logic       opt_block_info_erase, opt_block_main_read, opt_block_main_write;
  logic [7:0] rdata, prog_old_byte;
  logic       port_read, read_allow, op_busy, cpu_clk_stall;
  reg_req_t   req;
  prog_req_t  prog;
  flash_op_t  op, last_op;
  int         n_errors = 0, checks_done = 0, n_start = 0;

  flash_unlock_protect_program_control u_flash_unlock_protect_program_control (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .option_div_bit(option_div_bit),
    .stop_recovery_config(stop_recovery_config), .opt_block_info_erase(opt_block_info_erase),
    .opt_block_main_read(opt_block_main_read), .opt_block_main_write(opt_block_main_write),
    .req(req), .rdata(rdata), .prog(prog), .prog_old_byte(prog_old_byte), .port_read(port_read),
    .read_allow(read_allow), .op(op), .op_busy(op_busy), .cpu_clk_stall(cpu_clk_stall));
  req_model u_req_model (.sys_clk(sys_clk), .req(req), .prog(prog));

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  // Record every operation handed to the pulse timer
  always @(posedge sys_clk) begin
    if (op.start === 1'b1) begin
      n_start <= n_start + 1;
      last_op <= op;
    end
  end

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic code_is(input logic [5:0] c, input string nm);
    u_req_model.rd(ADDR_CMD);
    @(negedge sys_clk);
    `CHK(nm, {2'b00, c}, rdata)
  endtask : code_is
  task automatic starts_is(input int n, input string nm);
    repeat (3) @(negedge sys_clk);
    `CHK(nm, n, n_start)
  endtask : starts_is
  // Bounded wait: the longest operation here is one scaled page erase
  task automatic wait_idle();
    for (int i = 0; i < 12000 && op_busy !== 1'b0; i++) @(negedge sys_clk);
    `CHK("idle", 1'b0, op_busy)
  endtask : wait_idle

  task automatic t_reset();
    code_is(CODE_LOCKED, "reset code");
    `CHK("reset read gate", 1'b0, read_allow)
    `CHK("reset stall", 1'b0, cpu_clk_stall)
  endtask : t_reset
  task automatic t_unlock();
    u_req_model.wr(1'b0, ADDR_PAGE, 8'h05);
    u_req_model.wr(1'b0, ADDR_CMD, CMD_KEY1);
    code_is(CODE_KEY1, "key1 code");
    u_req_model.wr(1'b0, ADDR_CMD, CMD_KEY2);
    code_is(CODE_KEY2, "key2 code");
    u_req_model.wr(1'b0, ADDR_PAGE, 8'h05);
    code_is(CODE_UNLOCK, "unlocked code");
    u_req_model.wr(1'b0, ADDR_PAGE, 8'h05);
    code_is(CODE_LOCKED, "cpu page write");
    u_req_model.unlock(1'b0, 8'h05, 8'h06);
    code_is(CODE_LOCKED, "page mismatch");
    u_req_model.wr(1'b0, ADDR_PAGE, 8'h05);
    u_req_model.wr(1'b0, ADDR_CMD, CMD_KEY1);
    u_req_model.wr(1'b0, ADDR_CMD, 8'h74);
    code_is(CODE_LOCKED, "wrong key");
  endtask : t_unlock
  task automatic t_mass_cpu();
    int n0;
    n0 = n_start;
    u_req_model.unlock(1'b0, 8'h20, 8'h20);
    u_req_model.wr(1'b0, ADDR_CMD, CMD_MASS_ERA);
    starts_is(n0, "cpu mass erase");
    code_is(CODE_UNLOCK, "after cpu 63");
    u_req_model.wr(1'b0, ADDR_CMD, 8'h11);
    code_is(CODE_LOCKED, "other command");
  endtask : t_mass_cpu
  // Sector 0 protected, a clear attempted, then CPU refused and port served
  task automatic t_protect();
    int n0;
    n0 = n_start;
    u_req_model.wr(1'b0, ADDR_CMD, CMD_SEC_SEL);
    code_is(CODE_SECSEL, "sector select");
    u_req_model.wr(1'b0, ADDR_PAGE, 8'h01);
    u_req_model.protect(8'h00);
    u_req_model.unlock(1'b0, 8'h05, 8'h05);
    u_req_model.wr(1'b0, ADDR_CMD, CMD_PAGE_ERA);
    starts_is(n0, "protected cpu erase");
    u_req_model.wr(1'b0, ADDR_CMD, 8'h00);
    u_req_model.unlock(1'b1, 8'h05, 8'h05);
    u_req_model.wr(1'b1, ADDR_CMD, CMD_PAGE_ERA);
    starts_is(n0 + 1, "port erase");
    `CHK("port erase kind", OP_PERASE, last_op.kind)
    `CHK("port erase page", 8'h05, last_op.page)
    `CHK("port no stall", 1'b0, cpu_clk_stall)
    wait_idle();
    code_is(CODE_LOCKED, "erase relock");
    u_req_model.unlock(1'b1, 8'h05, 8'h05);
    prog_old_byte = 8'hFF;
    u_req_model.pgm(1'b1, 9'h001, 8'h3C);
    starts_is(n0 + 2, "port program");
    wait_idle();
    u_req_model.wr(1'b1, ADDR_CMD, 8'h00);
  endtask : t_protect
  task automatic t_cpu_erase_prog();
    int n0;
    n0 = n_start;
    u_req_model.unlock(1'b0, 8'h20, 8'h20);
    u_req_model.wr(1'b0, ADDR_CMD, CMD_PAGE_ERA);
    starts_is(n0 + 1, "cpu erase");
    `CHK("cpu erase page", 8'h20, last_op.page)
    `CHK("erase stall", 1'b1, cpu_clk_stall)
    wait_idle();
    `CHK("stall released", 1'b0, cpu_clk_stall)
    code_is(CODE_LOCKED, "cpu erase relock");
    u_req_model.unlock(1'b0, 8'h20, 8'h20);
    prog_old_byte = 8'hF0;
    u_req_model.pgm(1'b0, 9'h1A3, 8'h5A);
    starts_is(n0 + 2, "cpu program");
    `CHK("program data", 8'h50, last_op.wdata)
    `CHK("program offset", 9'h1A3, last_op.offset)
    `CHK("program stall", 1'b1, cpu_clk_stall)
    wait_idle();
    code_is(CODE_UNLOCK, "stays unlocked");
    `CHK("unlocked read gate", 1'b1, read_allow)
    opt_block_main_read = 1'b1;
    @(negedge sys_clk);
    `CHK("blocked port read", 1'b0, read_allow)
    u_req_model.pgm(1'b0, 9'h1A4, 8'h00);
    starts_is(n0 + 3, "second byte");
    wait_idle();
    u_req_model.wr(1'b0, ADDR_CMD, 8'h11);
    code_is(CODE_LOCKED, "exit programming");
    u_req_model.unlock(1'b0, INFO_PAGE3, INFO_PAGE3);
    u_req_model.pgm(1'b0, 9'h0C0, 8'h00);
    starts_is(n0 + 3, "cpu info program");
    u_req_model.wr(1'b0, ADDR_CMD, 8'h00);
  endtask : t_cpu_erase_prog

  // Watchdog: two scaled page erases plus short traffic fit well inside this span
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {sys_clk, option_div_bit, stop_recovery_config, port_read} = 4'h0;
    {opt_block_info_erase, opt_block_main_read, opt_block_main_write} = 3'h0;
    {sys_rst, clk_en, prog_old_byte} = {2'b11, 8'hFF};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    port_read = 1'b1;
    t_reset();
    u_req_model.load_timing(16'd1000);
    t_unlock();
    t_mass_cpu();
    t_protect();
    t_cpu_erase_prog();
    give_verdict();
  end
endmodule : testbench
